// ### rtl/sbm_regs.vh
/*
 * Constants for the dual-channel safety block monitor: timing figures,
 * derived cycle counts and the state codes of the block controller.
 * Assumes a 40 MHz system clock; included by bare name.
 */
`ifndef SBM_REGS_VH
`define SBM_REGS_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define SBM_CLK_KHZ 40000
`define SBM_GLITCH_US 500
`define SBM_MON_DELAY_US 8000
`define SBM_DISC_MS 10000
// Off pulses of 0.5 ms or shorter are ignored: the filter needs one cycle more.
`define SBM_GLITCH_CYC ((`SBM_GLITCH_US * `SBM_CLK_KHZ) / 1000 + 1)
// The delay runs after the filter has recognised both channels off, so the
// filter window and the synchroniser and register lag come off the budget.
`define SBM_MON_DELAY_CYC ((`SBM_MON_DELAY_US * `SBM_CLK_KHZ) / 1000 - `SBM_GLITCH_CYC - 4)
`define SBM_DISC_CYC (`SBM_DISC_MS * `SBM_CLK_KHZ)

// ****************************************************************
// Block controller states, one-hot
// ****************************************************************
`define SBM_ST_BB 3'h1
`define SBM_ST_RUN 3'h2
`define SBM_ST_HARD_SAFETY_BLOCK 3'h4

`endif

// ### rtl/sbm_chan_filter.v
/*
 * One safety input channel: two-stage synchroniser followed by an off-pulse
 * filter. Output is high while the channel is recognised as off.
 * Assumes the raw input is asynchronous to clk_sys and active low.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbm_regs.vh"

module sbm_chan_filter #(
	parameter FILT_CYC = `SBM_GLITCH_CYC,
	parameter CW = 16
) (
	input wire clk_sys,
	input wire rstn,
	input wire in_n,
	output reg off_r
);

reg meta_r;
reg sync_r;
reg [CW-1:0] cnt_r;

// First stage feeds only the second stage.
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		meta_r <= 1'b0;
		sync_r <= 1'b0;
	end else begin
		meta_r <= in_n;
		sync_r <= meta_r;
	end
end

// A channel is off from reset until seen high, and after that only once it stays low longer than the glitch window.
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		cnt_r <= {CW{1'b0}};
		off_r <= 1'b1;
	end else if (sync_r) begin
		cnt_r <= {CW{1'b0}};
		off_r <= 1'b0;
	end else if (cnt_r >= FILT_CYC[CW-1:0] - 1'b1) begin
		off_r <= 1'b1;
	end else begin
		cnt_r <= cnt_r + 1'b1;
	end
end

endmodule
`default_nettype wire

// ### rtl/sbm_monitor.v
/*
 * Dual-channel hard safety block monitor of a servo drive.
 * Assumes safety inputs arrive asynchronously from an external safety
 * controller, and servo enable, healthy and alarm request come from drive
 * logic on clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbm_regs.vh"

module sbm_monitor #(
	parameter MON_DELAY_CYC = `SBM_MON_DELAY_CYC,
	parameter DISC_CYC = `SBM_DISC_CYC,
	parameter CW = 19,
	parameter DW = 29
) (
	input wire clk_sys,
	input wire rstn,
	input wire safety_input_a_n,
	input wire safety_input_b_n,
	input wire servo_enable,
	input wire safety_healthy,
	input wire alarm_request,
	output reg external_monitor_out,
	output reg servo_alarm_out,
	output reg input_timing_alarm,
	output reg hard_safety_block,
	output reg base_blocked_state,
	output reg servo_ready,
	output reg block_indication,
	output reg motor_current_enable
);

// ****************************************************************
// Input channels
// ****************************************************************
// An absent jumper leaves the inputs open, which the filter reads as off.
wire [1:0] chan_off;
wire [1:0] chan_in_n;
assign chan_in_n = {safety_input_b_n, safety_input_a_n};

genvar gi;
generate
	for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
		sbm_chan_filter u_filt (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.in_n(chan_in_n[gi]),
			.off_r(chan_off[gi])
		);
	end
endgenerate

wire any_off = chan_off[0] | chan_off[1];
wire both_off = chan_off[0] & chan_off[1];
wire one_off = chan_off[0] ^ chan_off[1];

// ****************************************************************
// Block controller
// ****************************************************************
reg [2:0] state_r;
reg [2:0] state_nxt;
reg en_latch_r;

always @* begin
	state_nxt = state_r;
	case (state_r)
	`SBM_ST_BB: begin
		if (any_off)
			state_nxt = `SBM_ST_HARD_SAFETY_BLOCK;
		else if (servo_enable)
			state_nxt = `SBM_ST_RUN;
	end
	`SBM_ST_RUN: begin
		if (any_off)
			state_nxt = `SBM_ST_HARD_SAFETY_BLOCK;
		else if (!servo_enable)
			state_nxt = `SBM_ST_BB;
	end
	`SBM_ST_HARD_SAFETY_BLOCK: begin
		// Leaving needs both channels on and no enable held over the block.
		if (!any_off && !servo_enable && !en_latch_r)
			state_nxt = `SBM_ST_BB;
	end
	default: state_nxt = `SBM_ST_HARD_SAFETY_BLOCK;
	endcase
end

always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		state_r <= `SBM_ST_HARD_SAFETY_BLOCK;
		en_latch_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		if (state_r == `SBM_ST_HARD_SAFETY_BLOCK && servo_enable)
			en_latch_r <= 1'b1;
		else if (!servo_enable)
			en_latch_r <= 1'b0;
	end
end

// ****************************************************************
// Monitor delay and discrepancy timers
// ****************************************************************
// The monitor stays off while the safety function is unhealthy, so the
// external controller sees the failure and refuses its reset.
reg [CW-1:0] mon_cnt_r;
reg [DW-1:0] disc_cnt_r;

always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		mon_cnt_r <= {CW{1'b0}};
		external_monitor_out <= 1'b0;
		disc_cnt_r <= {DW{1'b0}};
		input_timing_alarm <= 1'b0;
	end else begin
		if (!both_off || !safety_healthy) begin
			mon_cnt_r <= {CW{1'b0}};
			external_monitor_out <= 1'b0;
		end else if (mon_cnt_r >= MON_DELAY_CYC[CW-1:0] - 1'b1) begin
			external_monitor_out <= 1'b1;
		end else begin
			mon_cnt_r <= mon_cnt_r + 1'b1;
		end
		// Alarm is sticky until reset; a half-open channel is a wiring fault.
		if (!one_off) begin
			disc_cnt_r <= {DW{1'b0}};
		end else if (disc_cnt_r >= DISC_CYC[DW-1:0] - 1'b1) begin
			input_timing_alarm <= 1'b1;
		end else begin
			disc_cnt_r <= disc_cnt_r + 1'b1;
		end
	end
end

// ****************************************************************
// Status outputs
// ****************************************************************
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		hard_safety_block <= 1'b1;
		base_blocked_state <= 1'b0;
		servo_ready <= 1'b0;
		block_indication <= 1'b1;
		motor_current_enable <= 1'b0;
		servo_alarm_out <= 1'b0;
	end else begin
		hard_safety_block <= (state_nxt == `SBM_ST_HARD_SAFETY_BLOCK);
		base_blocked_state <= (state_nxt == `SBM_ST_BB);
		servo_ready <= (state_nxt == `SBM_ST_BB) && !any_off;
		block_indication <= (state_nxt == `SBM_ST_HARD_SAFETY_BLOCK);
		motor_current_enable <= (state_nxt == `SBM_ST_RUN) && !any_off;
		servo_alarm_out <= alarm_request && (state_nxt != `SBM_ST_HARD_SAFETY_BLOCK);
	end
end

endmodule
`default_nettype wire

// ### verification/sbm_monitor_chk.sv
/* Port checker for sbm_monitor.
   Assumes a bind from the bench that hands on the shortened counts. */
`timescale 1ns/100ps
`default_nettype none
module sbm_monitor_chk #(
	parameter MON_DELAY_CYC = 8,
	parameter DISC_CYC = 50
) (
	input wire logic clk_sys, rstn, safety_input_a_n, safety_input_b_n,
	input wire logic servo_enable, safety_healthy, external_monitor_out, servo_alarm_out,
	input wire logic input_timing_alarm, hard_safety_block, base_blocked_state,
	input wire logic servo_ready, block_indication, motor_current_enable
);
	localparam int MON_LIM = 20010 + MON_DELAY_CYC;
	// Runs are counted at the pins, so synchroniser and filter lag fall inside them.
	logic [15:0] both_r, low_r, disc_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn) begin
			both_r <= 16'h0;
			low_r <= 16'h0;
			disc_r <= 16'h0;
		end else begin
			both_r <= (!safety_input_a_n && !safety_input_b_n && safety_healthy) ? both_r + 16'h1 : 16'h0;
			low_r <= (!safety_input_a_n || !safety_input_b_n) ? low_r + 16'h1 : 16'h0;
			disc_r <= (safety_input_a_n != safety_input_b_n) ? disc_r + 16'h1 : 16'h0;
		end
	sequence s_both_on;
		(safety_input_a_n && safety_input_b_n) [*8];
	endsequence
	property p_mon_off; s_both_on |-> !external_monitor_out; endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor on with inputs on");
	property p_mon_time; both_r == MON_LIM |-> external_monitor_out; endproperty
	a_mon_time: assert property (p_mon_time) else $error("monitor late");
	property p_alarm; hard_safety_block |-> !servo_alarm_out; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm in block");
	property p_block; hard_safety_block |-> block_indication && !motor_current_enable; endproperty
	a_block: assert property (p_block) else $error("block outputs wrong");
	property p_ready; servo_ready |-> base_blocked_state && !hard_safety_block; endproperty
	a_ready: assert property (p_ready) else $error("ready outside idle");
	property p_leave; $fell(hard_safety_block) |-> base_blocked_state && !$past(servo_enable); endproperty
	a_leave: assert property (p_leave) else $error("block left with enable");
	property p_filter; $rose(hard_safety_block) |-> low_r > 16'd20000; endproperty
	a_filter: assert property (p_filter) else $error("short pulse blocked");
	property p_disc; $rose(input_timing_alarm) |-> disc_r >= DISC_CYC; endproperty
	a_disc: assert property (p_disc) else $error("timing alarm early");
endmodule
`default_nettype wire

// ### verification/sbm_safety_ctrl.sv
/* Model of the external safety controller and its guard.
   Assumes the bench drives guard, test dip and stuck fault on clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module sbm_safety_ctrl (
	input wire logic clk_sys,
	input wire logic guard_open,
	input wire logic dip,
	input wire logic stuck_b,
	input wire logic mon,
	output logic a_n,
	output logic b_n
);
	logic held_r = 1'b0;
	// Re-arming only through the feedback, so a stuck channel keeps the other off.
	always @(posedge clk_sys)
		if (guard_open)
			held_r <= 1'b1;
		else if (mon)
			held_r <= 1'b0;
	assign a_n = !(held_r || dip);
	assign b_n = !((held_r && !stuck_b) || dip);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/* Bench for sbm_monitor with a safety controller model.
   Assumes shortened monitor and discrepancy counts. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'b0, rstn = 1'b0, servo_enable = 1'b0, safety_healthy = 1'b1, alarm_request = 1'b0;
	logic guard_open = 1'b0, dip = 1'b0, stuck_b = 1'b0, safety_input_a_n, safety_input_b_n;
	logic external_monitor_out, servo_alarm_out, input_timing_alarm, hard_safety_block;
	logic base_blocked_state, servo_ready, block_indication, motor_current_enable;
	int error_cnt = 0;
	int samples_checked = 0;
	sbm_monitor #(.MON_DELAY_CYC(8), .DISC_CYC(50)) i_sbm_monitor (.*);
	sbm_safety_ctrl i_sbm_safety_ctrl (.clk_sys(clk_sys), .guard_open(guard_open), .dip(dip),
		.stuck_b(stuck_b), .mon(external_monitor_out), .a_n(safety_input_a_n), .b_n(safety_input_b_n));
	initial forever #12.5 clk_sys = !clk_sys;
	task automatic chk(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_run;
		chk(servo_ready, 1'b1);
		chk(base_blocked_state, 1'b1);
		@(posedge clk_sys) servo_enable <= 1'b1;
		alarm_request <= 1'b1;
		tick(3);
		chk(servo_ready, 1'b0);
		chk(servo_alarm_out, 1'b1);
		chk(motor_current_enable, 1'b1);
		chk(base_blocked_state, 1'b0);
		chk(hard_safety_block, 1'b0);
		@(posedge clk_sys) guard_open <= 1'b1;
		for (int i = 0; i < 20010 && hard_safety_block !== 1'b1; i++) @(negedge clk_sys);
		chk(motor_current_enable, 1'b0);
		chk(block_indication, 1'b1);
		chk(servo_alarm_out, 1'b0);
		tick(10);
		chk(external_monitor_out, 1'b1);
		@(posedge clk_sys) safety_healthy <= 1'b0;
		tick(3);
		chk(external_monitor_out, 1'b0);
		@(posedge clk_sys) safety_healthy <= 1'b1;
		tick(12);
		chk(external_monitor_out, 1'b1);
		@(posedge clk_sys) guard_open <= 1'b0;
		tick(20);
		chk(hard_safety_block, 1'b1);
		chk(external_monitor_out, 1'b0);
		@(posedge clk_sys) servo_enable <= 1'b0;
		tick(6);
		chk(servo_ready, 1'b1);
		chk(servo_alarm_out, 1'b1);
		chk(input_timing_alarm, 1'b0);
		$display("run done");
	endtask
	task automatic t_dip;
		@(posedge clk_sys) dip <= 1'b1;
		repeat (20000) @(posedge clk_sys);
		dip <= 1'b0;
		tick(8);
		chk(hard_safety_block, 1'b0);
		$display("dip done");
	endtask
	// The motor is stopped by command before the guard opens.
	task automatic t_stuck;
		@(posedge clk_sys) stuck_b <= 1'b1;
		guard_open <= 1'b1;
		tick(20080);
		chk(input_timing_alarm, 1'b1);
		chk(external_monitor_out, 1'b0);
		$display("stuck done");
	endtask
	initial begin
		tick(5);
		chk(hard_safety_block, 1'b1);
		tick(5);
		@(posedge clk_sys) rstn <= 1'b1;
		tick(10);
		t_run();
		t_dip();
		t_stuck();
		test_done();
	end
	initial begin
		tick(70000);
		error_cnt++;
		$display("Error at %0t: timeout", $time);
		test_done();
	end
endmodule
bind sbm_monitor sbm_monitor_chk #(.MON_DELAY_CYC(MON_DELAY_CYC), .DISC_CYC(DISC_CYC)) i_sbm_monitor_chk (.*);
`default_nettype wire
